/* File: rtl/sac_pkg.sv */
// sac_pkg: constants, types and register map of the converter sequencer
// assumes a plain register port with one-cycle read latency
// Operation
// R1 - all-ones channel code disables module, no input connected
// R2 - code 01111 routes analog channel fifteen to the converter
// R3 - up to 28 inputs, chosen only by channel select field
// R4 - clock source: bus, bus halved, local async, alternate clock
// R5 - conversion clock is selected source divided by divider field
// R6 - alternate clock keeps running in wait mode
// R7 - software avoids alternate clock when converting in stop modes
// R8 - hardware trigger starts conversion on counter overflow
// R9 - trigger works whatever the counter interrupt enable holds
// R10 - counter triggers accepted in run, wait and shallow stop
// R11 - linear successive approximation resolving ten bits
// R12 - result right-justified unsigned, 10-bit or 8-bit
// R13 - single or continuous; single returns to idle itself
// R14 - conversion complete flag with interrupt request
// R15 - optional compare, less-than or greater-or-equal, interrupt on match
// R16 - sample time and speed/power set by software
// R17 - conversions proceed in wait and shallow stop modes
// R18 - software sets long sample, slow clock, bandgap before temperature
// R19 - reserved channel codes still convert, value undefined
// R20 - writing status_control_one aborts and restarts unless disabled; code restarts only while hardware trigger is off
// R21 - complete flag clears on status_control_one write or low read
// R22 - active flag sets at start, clears on completion or abort
// R23 - async domain results synchronised before updating flags
// R24 - after reset idle, not active, complete flag clear
package sac_pkg;
    // register offsets
    localparam logic [2:0] SAC_ADDR_SC1 = 3'h0; // status_control_one
    localparam logic [2:0] SAC_ADDR_SC2 = 3'h1;
    localparam logic [2:0] SAC_ADDR_RH = 3'h2;
    localparam logic [2:0] SAC_ADDR_RL = 3'h3; // result_low_byte
    localparam logic [2:0] SAC_ADDR_CVH = 3'h4;
    localparam logic [2:0] SAC_ADDR_CVL = 3'h5;
    localparam logic [2:0] SAC_ADDR_CFG = 3'h6;
    localparam logic [4:0] SAC_CH_OFF = 5'h1f;
    localparam logic [4:0] SAC_CH_FIFTEEN = 5'h0f;
    localparam int SAC_NCH = 28;
    localparam int SAC_RES_BITS = 10;
    localparam logic [3:0] SAC_BIT_TOP = 4'h9;
    localparam logic [4:0] SAC_SAMPLE_SHORT = 5'h03;
    localparam logic [4:0] SAC_SAMPLE_LONG = 5'h17;
    localparam logic [1:0] SAC_MODE_10 = 2'h2;
    localparam logic [7:0] SAC_SC1_RESET = 8'h1f;
    // clock sources
    localparam logic [1:0] SAC_CLK_BUS = 2'h0;
    localparam logic [1:0] SAC_CLK_BUS2 = 2'h1;
    localparam logic [1:0] SAC_CLK_ALT = 2'h2;
    localparam logic [1:0] SAC_CLK_ASYNC = 2'h3;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sac_bus_t;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic [1:0] div_sel;
        logic long_sample;
        logic low_power;
        logic [1:0] mode;
    } sac_cfg_t;

    typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_CONVERT} sac_state_t;
endpackage

/* File: rtl/sac_clkdiv.sv */
// sac_clkdiv: conversion clock tick from the chosen source and divider
// assumes all sources are on ref_clk or raw pins from other clocks
`timescale 1ns/100ps
`default_nettype none
module sac_clkdiv
    import sac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // selection
    input wire logic [1:0] clk_sel,
    input wire logic [1:0] div_sel,
    // raw source clocks from other domains
    input wire logic alternate_clock,
    input wire logic local_async_clock,
    // one-cycle tick of the conversion clock
    output logic tick
);
    typedef struct packed {
        logic [2:0] alt_s;
        logic [2:0] asy_s;
        logic half;
        logic [2:0] cnt;
        logic tick;
    } sac_div_t;
    sac_div_t st_reg, st_next;
    logic src_edge;

    // source edge per selection [R4]
    always_comb begin
        st_next = st_reg;
        st_next.alt_s = {st_reg.alt_s[1:0], alternate_clock}; // [R6]
        st_next.asy_s = {st_reg.asy_s[1:0], local_async_clock}; // [R23]
        st_next.half = ~st_reg.half;
        unique case (clk_sel)
            SAC_CLK_BUS: src_edge = 1'b1;
            SAC_CLK_BUS2: src_edge = st_reg.half;
            SAC_CLK_ALT: src_edge = st_reg.alt_s[1] & ~st_reg.alt_s[2];
            SAC_CLK_ASYNC: src_edge = st_reg.asy_s[1] & ~st_reg.asy_s[2];
        endcase
        // divide by 1,2,4,8 [R5]
        st_next.tick = 1'b0;
        if (src_edge) begin
            st_next.cnt = st_reg.cnt + 3'h1;
            st_next.tick = ((st_reg.cnt & ((3'h1 << div_sel) - 3'h1)) ==
                ((3'h1 << div_sel) - 3'h1));
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule
`default_nettype wire

/* File: rtl/sac_top.sv */
// sac_top: successive-approximation sequencer with register port
// assumes comparator input from analog core; trigger from counter block
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sac_top
    import sac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire sac_pkg::sac_bus_t bus_in,
    output logic [7:0] rdata,
    // clock sources and trigger
    input wire logic alternate_clock,
    input wire logic local_async_clock,
    input wire logic hardware_trigger,
    // analog core
    input wire logic cmp_in,
    output logic [SAC_RES_BITS-1:0] dac_code,
    output logic [4:0] mux_sel,
    output logic mux_en,
    output logic sample_en,
    // status
    output logic conv_irq,
    output logic conversion_active_flag
);
    import sac_pkg::*;

    typedef struct packed {
        sac_state_t fsm;
        logic [7:0] sc1;
        logic hw_en;
        logic cmp_en;
        logic cmp_ge;
        logic [9:0] cv;
        sac_cfg_t cfg;
        logic [9:0] result;
        logic [9:0] sar;
        logic [3:0] bitn;
        logic [4:0] scnt;
        logic conversion_complete_flag;
        logic active;
        logic [2:0] trg_s;
        logic [7:0] rdata;
        logic irq;
        logic [9:0] dac;
        logic mux_en;
        logic samp;
    } sac_st_t;
    sac_st_t st_reg, st_next;
    logic tick;
    logic [9:0] fmt;
    logic [9:0] trial;
    logic [9:0] fin;
    logic match;

    // conversion clock divider
    sac_clkdiv u_div (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_sel(st_reg.cfg.clk_sel),
        .div_sel(st_reg.cfg.div_sel),
        .alternate_clock(alternate_clock),
        .local_async_clock(local_async_clock),
        .tick(tick)
    );

    // next state
    always_comb begin
        st_next = st_reg;
        // trigger pin synchroniser, edge on stages 2 and 3 [R9] [R10]
        st_next.trg_s = {st_reg.trg_s[1:0], hardware_trigger};
        trial = st_reg.sar | (10'h200 >> st_reg.bitn);
        // final code with the last trial bit, so compare sees the result
        fin = cmp_in ? trial : st_reg.sar;
        // result format, 8-bit mode drops two lsbs [R12]
        fmt = (st_reg.cfg.mode == SAC_MODE_10) ? fin :
            {2'h0, fin[9:2]};
        match = st_reg.cmp_ge ? (fmt >= st_reg.cv) : (fmt < st_reg.cv); // [R15]
        st_next.rdata = 8'h00;

        // register reads, low byte read clears flag [R21]
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                SAC_ADDR_SC1: st_next.rdata = {st_reg.conversion_complete_flag, st_reg.sc1[6:0]};
                SAC_ADDR_SC2: st_next.rdata = {st_reg.active, 1'b0,
                    st_reg.hw_en, st_reg.cmp_en, st_reg.cmp_ge, 3'h0};
                SAC_ADDR_RH: st_next.rdata = {6'h00, st_reg.result[9:8]};
                SAC_ADDR_RL: begin
                    st_next.rdata = st_reg.result[7:0];
                    st_next.conversion_complete_flag = 1'b0;
                end
                SAC_ADDR_CVH: st_next.rdata = {6'h00, st_reg.cv[9:8]};
                SAC_ADDR_CVL: st_next.rdata = st_reg.cv[7:0];
                SAC_ADDR_CFG: st_next.rdata = {st_reg.cfg.low_power,
                    st_reg.cfg.div_sel, st_reg.cfg.long_sample,
                    st_reg.cfg.mode, st_reg.cfg.clk_sel};
                default: st_next.rdata = 8'h00;
            endcase
        end

        // sequencer on conversion clock ticks [R11] [R17]
        if (tick) begin
            unique case (st_reg.fsm)
                SAC_IDLE: ;
                SAC_SAMPLE: begin
                    if (st_reg.scnt == 5'h00) begin
                        st_next.fsm = SAC_CONVERT;
                        st_next.samp = 1'b0;
                        st_next.bitn = 4'h0;
                        st_next.dac = 10'h200;
                    end else begin
                        st_next.scnt = st_reg.scnt - 5'h01;
                    end
                end
                SAC_CONVERT: begin
                    if (cmp_in) begin
                        st_next.sar = trial;
                    end
                    if (st_reg.bitn == SAC_BIT_TOP) begin
                        // finish: result and flag, then idle or repeat [R13]
                        st_next.sar = cmp_in ? trial : st_reg.sar;
                        st_next.active = 1'b0; // [R22]
                        st_next.fsm = SAC_IDLE;
                        st_next.mux_en = 1'b0;
                        if (st_reg.sc1[5] && !st_reg.hw_en) begin
                            st_next.fsm = SAC_SAMPLE;
                            st_next.active = 1'b1;
                            st_next.mux_en = 1'b1;
                            st_next.samp = 1'b1;
                            st_next.scnt = st_reg.cfg.long_sample ?
                                SAC_SAMPLE_LONG : SAC_SAMPLE_SHORT; // [R16]
                            st_next.sar = '0;
                        end
                    end else begin
                        st_next.bitn = st_reg.bitn + 4'h1;
                        st_next.dac = (cmp_in ? trial : st_reg.sar) |
                            (10'h100 >> st_reg.bitn);
                    end
                end
                default: st_next.fsm = SAC_IDLE;
            endcase
        end

        // completion writes result once sar is final, flag set when compare is off or matches [R14]
        if (st_reg.fsm == SAC_CONVERT && st_next.fsm != SAC_CONVERT) begin
            st_next.result = fmt;
            if (!st_reg.cmp_en || match) begin
                st_next.conversion_complete_flag = 1'b1; // set wins over read clear
            end
        end

        // hardware trigger on counter overflow [R8]
        if (st_reg.hw_en && st_reg.trg_s[1] && !st_reg.trg_s[2] &&
            st_reg.sc1[4:0] != SAC_CH_OFF && st_reg.fsm == SAC_IDLE) begin
            st_next.fsm = SAC_SAMPLE;
            st_next.active = 1'b1; // [R22]
            st_next.mux_en = 1'b1;
            st_next.samp = 1'b1;
            st_next.sar = '0;
            st_next.scnt = st_reg.cfg.long_sample ?
                SAC_SAMPLE_LONG : SAC_SAMPLE_SHORT;
        end

        // register writes
        if (bus_in.wr) begin
            unique case (bus_in.addr)
                SAC_ADDR_SC1: begin
                    st_next.sc1 = bus_in.wdata;
                    st_next.conversion_complete_flag = 1'b0; // [R21]
                    st_next.fsm = SAC_IDLE; // abort [R20]
                    st_next.active = 1'b0;
                    st_next.mux_en = 1'b0;
                    st_next.samp = 1'b0;
                    if (bus_in.wdata[4:0] != SAC_CH_OFF && !st_reg.hw_en) begin
                        // channel chosen only by field [R2] [R3] [R19]
                        st_next.fsm = SAC_SAMPLE;
                        st_next.active = 1'b1;
                        st_next.mux_en = 1'b1; // [R1]
                        st_next.samp = 1'b1;
                        st_next.sar = '0;
                        st_next.scnt = st_reg.cfg.long_sample ?
                            SAC_SAMPLE_LONG : SAC_SAMPLE_SHORT;
                    end
                end
                SAC_ADDR_SC2: begin
                    st_next.hw_en = bus_in.wdata[5];
                    st_next.cmp_en = bus_in.wdata[4];
                    st_next.cmp_ge = bus_in.wdata[3];
                end
                SAC_ADDR_CVH: st_next.cv[9:8] = bus_in.wdata[1:0];
                SAC_ADDR_CVL: st_next.cv[7:0] = bus_in.wdata;
                SAC_ADDR_CFG: st_next.cfg = {bus_in.wdata[1:0],
                    bus_in.wdata[6:5], bus_in.wdata[4], bus_in.wdata[7],
                    bus_in.wdata[3:2]};
                default: ;
            endcase
        end
        st_next.irq = st_next.conversion_complete_flag & st_next.sc1[6]; // [R14] [R15]
    end

    // state register, reset to idle [R24]
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.sc1 <= SAC_SC1_RESET;
            st_reg.fsm <= SAC_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs from registers
    assign rdata = st_reg.rdata;
    assign dac_code = st_reg.dac;
    assign mux_sel = st_reg.sc1[4:0];
    assign mux_en = st_reg.mux_en;
    assign sample_en = st_reg.samp;
    assign conv_irq = st_reg.irq;
    assign conversion_active_flag = st_reg.active;
endmodule
`default_nettype wire

/* File: tb/sac_monitor.sv */
// sac_monitor: port-level checks of the converter sequencer
// assumes bound to sac_top; one ref_clk domain, rst_b active low
`timescale 1ns/100ps
`default_nettype none
module sac_monitor
    import sac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // watched ports
    input wire sac_pkg::sac_bus_t bus_in,
    input wire logic hardware_trigger,
    input wire logic [4:0] mux_sel,
    input wire logic mux_en,
    input wire logic sample_en,
    input wire logic conv_irq,
    input wire logic conversion_active_flag
);
    logic hw_en_reg;
    logic [4:0] ch_reg;
    logic sc1_wr;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // shadow of trigger mode and channel from bus writes
    assign sc1_wr = bus_in.wr && bus_in.addr == SAC_ADDR_SC1;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hw_en_reg <= 1'b0;
            ch_reg <= SAC_CH_OFF;
        end else begin
            if (bus_in.wr && bus_in.addr == SAC_ADDR_SC2)
                hw_en_reg <= bus_in.wdata[5];
            if (sc1_wr)
                ch_reg <= bus_in.wdata[4:0];
        end
    end
    reset_idle_a: assert property ($rose(rst_b) |->
        !conversion_active_flag && mux_sel == SAC_CH_OFF && !conv_irq)
        else $error("busy after reset");
    sw_start_a: assert property (sc1_wr && !hw_en_reg &&
        bus_in.wdata[4:0] != SAC_CH_OFF |=> conversion_active_flag
        && mux_sel == $past(bus_in.wdata[4:0]))
        else $error("write did not start");
    sw_stop_a: assert property (sc1_wr &&
        bus_in.wdata[4:0] == SAC_CH_OFF |=> !conversion_active_flag)
        else $error("disable did not stop");
    off_never_a: assert property (conversion_active_flag |->
        mux_sel != SAC_CH_OFF) else $error("disabled code converting");
    active_mux_a: assert property (conversion_active_flag |->
        mux_en) else $error("active without input");
    sample_in_a: assert property (sample_en |->
        conversion_active_flag) else $error("sampling while idle");
    irq_clear_a: assert property (sc1_wr |-> ##2 !conv_irq)
        else $error("irq kept after write");
    hw_start_a: assert property (hw_en_reg && ch_reg != SAC_CH_OFF &&
        $rose(hardware_trigger) && !conversion_active_flag
        |-> ##[1:5] conversion_active_flag) else $error("no hw start");
endmodule
`default_nettype wire

/* File: tb/sac_afe_model.sv */
// sac_afe_model: behavioural analog front end facing the sequencer
// assumes channel level is ain_base xor channel code
`timescale 1ns/100ps
`default_nettype none
module sac_afe_model (
    // clock
    input wire logic ref_clk,
    // level set by the bench
    input wire logic [9:0] ain_base,
    // controls from the sequencer
    input wire logic [9:0] dac_code,
    input wire logic [4:0] mux_sel,
    input wire logic mux_en,
    input wire logic sample_en,
    // comparator answer
    output logic cmp_in
);
    logic [9:0] hold_reg;
    logic idle_reg = 1'b0;
    // track and hold the routed channel
    always_ff @(posedge ref_clk) begin
        idle_reg <= ~idle_reg;
        if (mux_en && sample_en)
            hold_reg <= ain_base ^ {5'h00, mux_sel};
    end
    // unconnected input gives a changing, useless answer
    assign cmp_in = mux_en ? (hold_reg >= dac_code) : idle_reg;
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// testbench: scenario tasks for the converter sequencer
// assumes sac_top, sac_afe_model and sac_monitor compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sac_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic alternate_clock = 1'b0;
    logic local_async_clock = 1'b0;
    logic hardware_trigger = 1'b0;
    sac_bus_t bus_in = '0;
    logic [9:0] ain_base = 10'h2a5;
    logic [7:0] rdata, rd_val;
    logic cmp_in, mux_en, sample_en, conv_irq, conversion_active_flag;
    logic [9:0] dac_code;
    logic [4:0] mux_sel;
    int bad_count = 0;
    int checks_done = 0;
    // bus clock and two unrelated source clocks
    always #10 ref_clk = ~ref_clk;
    always #37 alternate_clock = ~alternate_clock;
    always #23 local_async_clock = ~local_async_clock;
    sac_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .bus_in(bus_in),
        .rdata(rdata), .alternate_clock(alternate_clock),
        .local_async_clock(local_async_clock),
        .hardware_trigger(hardware_trigger), .cmp_in(cmp_in),
        .dac_code(dac_code), .mux_sel(mux_sel), .mux_en(mux_en),
        .sample_en(sample_en), .conv_irq(conv_irq),
        .conversion_active_flag(conversion_active_flag));
    sac_afe_model afe (.ref_clk(ref_clk), .ain_base(ain_base),
        .dac_code(dac_code), .mux_sel(mux_sel), .mux_en(mux_en),
        .sample_en(sample_en), .cmp_in(cmp_in));
    // compare and count
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // register port cycles
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_in.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge ref_clk);
        bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_in.rd <= 1'b0;
        #1 rd_val = rdata;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        @(negedge ref_clk);
        check(conversion_active_flag, 1'b1);
        while (conversion_active_flag !== 1'b0 && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        check(n < 3000, 1'b1);
        @(negedge ref_clk);
    endtask
    task automatic result(input logic [4:0] ch, input logic ten);
        logic [9:0] v;
        v = ain_base ^ {5'h00, ch};
        rd(SAC_ADDR_RH);
        check(rd_val, ten ? {8'h00, v[9:8]} : 10'h000);
        rd(SAC_ADDR_RL);
        check(rd_val, ten ? {2'h0, v[7:0]} : {2'h0, v[9:2]});
        rd(SAC_ADDR_SC1);
        check(rd_val[7], 1'b0);
    endtask
    task automatic t_reset;
        rd(SAC_ADDR_SC1);
        check(rd_val, 10'h01f);
        rd(SAC_ADDR_SC2);
        check(rd_val, 10'h000);
        rd(3'h7);
        check(rd_val, 10'h000);
        $display("reset test done");
    endtask
    task automatic t_single;
        wr(SAC_ADDR_CFG, 8'h08);
        wr(SAC_ADDR_SC1, 8'h4f);
        wait_done();
        check(conv_irq, 1'b1);
        result(5'h0f, 1'b1);
        check(conv_irq, 1'b0);
        wr(SAC_ADDR_CFG, 8'h00);
        wr(SAC_ADDR_SC1, 8'h03);
        wait_done();
        result(5'h03, 1'b0);
        $display("single test done");
    endtask
    task automatic t_clocks;
        for (int i = 0; i < 4; i++) begin
            wr(SAC_ADDR_CFG, {1'b0, i[1:0], i[0], 2'h2, i[1:0]});
            wr(SAC_ADDR_SC1, 8'h05);
            wait_done();
            result(5'h05, 1'b1);
        end
        // long sample, async clock divided by eight, bandgap before temperature
        wr(SAC_ADDR_CFG, 8'h7b);
        wr(SAC_ADDR_SC1, 8'h1b);
        wait_done();
        result(5'h1b, 1'b1);
        wr(SAC_ADDR_SC1, 8'h1a);
        wait_done();
        result(5'h1a, 1'b1);
        $display("clock test done");
    endtask
    task automatic t_compare;
        wr(SAC_ADDR_CFG, 8'h08);
        ain_base <= 10'h080;
        wr(SAC_ADDR_CVH, 8'h01);
        wr(SAC_ADDR_CVL, 8'h00);
        wr(SAC_ADDR_SC2, 8'h18);
        wr(SAC_ADDR_SC1, 8'h00);
        wait_done();
        rd(SAC_ADDR_SC1);
        check(rd_val, 10'h000);
        wr(SAC_ADDR_SC2, 8'h10);
        wr(SAC_ADDR_SC1, 8'h00);
        wait_done();
        rd(SAC_ADDR_SC1);
        check(rd_val, 10'h080);
        check(conv_irq, 1'b0);
        // last bit decides the compare
        ain_base <= 10'h0ff;
        wr(SAC_ADDR_CVH, 8'h00);
        wr(SAC_ADDR_CVL, 8'hff);
        wr(SAC_ADDR_SC2, 8'h18);
        wr(SAC_ADDR_SC1, 8'h00);
        wait_done();
        rd(SAC_ADDR_SC1);
        check(rd_val, 10'h080);
        wr(SAC_ADDR_SC2, 8'h00);
        $display("compare test done");
    endtask
    task automatic t_hw;
        int n;
        n = 0;
        wr(SAC_ADDR_SC2, 8'h20);
        wr(SAC_ADDR_SC1, 8'h02);
        repeat (4) @(negedge ref_clk);
        check(conversion_active_flag, 1'b0);
        @(posedge ref_clk);
        hardware_trigger <= 1'b1;
        while (conversion_active_flag !== 1'b1 && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
        wait_done();
        result(5'h02, 1'b1);
        hardware_trigger <= 1'b0;
        wr(SAC_ADDR_SC2, 8'h00);
        $display("trigger test done");
    endtask
    task automatic t_abort;
        wr(SAC_ADDR_CFG, 8'h6b);
        wr(SAC_ADDR_SC1, 8'h27);
        repeat (20) @(negedge ref_clk);
        check(mux_sel, 5'h07);
        wr(SAC_ADDR_SC1, 8'h09);
        @(negedge ref_clk);
        check({conversion_active_flag, mux_sel}, 6'h29);
        wr(SAC_ADDR_SC1, 8'h3f);
        @(negedge ref_clk);
        check({conversion_active_flag, mux_en}, 2'h0);
        repeat (400) @(negedge ref_clk);
        check(conversion_active_flag, 1'b0);
        wr(SAC_ADDR_SC1, 8'h01);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        check({conversion_active_flag, mux_sel}, 6'h1f);
        $display("abort test done");
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_single();
        t_clocks();
        t_compare();
        t_hw();
        t_abort();
        close_out();
    end
    // watchdog
    initial begin
        repeat (50000) @(posedge ref_clk);
        bad_count++;
        close_out();
    end
endmodule
bind sac_top sac_monitor mon (.ref_clk(ref_clk), .rst_b(rst_b),
    .bus_in(bus_in), .hardware_trigger(hardware_trigger),
    .mux_sel(mux_sel), .mux_en(mux_en), .sample_en(sample_en),
    .conv_irq(conv_irq), .conversion_active_flag(conversion_active_flag));
`default_nettype wire
